// ---- bench/arc_field_model.sv ----
// far-side model: light sensors, protection inputs, heartbeat
// assumes bench requests change just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none
module arc_field_model
(
  input  wire logic       clk,
  input  wire logic       hb_run,
  input  wire logic [3:0] light_req,
  input  wire logic       flag_req,
  input  wire logic       reset_req,
  output var  logic [3:0] light,
  output var  logic       flag,
  output var  logic       ext_reset,
  output var  logic       heartbeat
);
  logic [6:0] hb_count = 7'h00;
  initial
  begin
    {light, flag, ext_reset, heartbeat} = 7'h00;
  end
  always @(posedge clk)
  begin
    light     <= light_req;
    flag      <= flag_req;
    ext_reset <= reset_req;
  end
  // toggles every 50 cycles, well inside the supervision timeout
  always @(posedge clk)
  begin
    hb_count <= (hb_count == 7'h31) ? 7'h00 : hb_count + 7'h01;
    if (hb_run && hb_count == 7'h31)
    begin
      heartbeat <= ~heartbeat;
    end
  end
endmodule
`default_nettype wire

// ---- bench/arc_trip_matrix_test.sv ----
// self-checking bench for the arc trip matrix
// assumes a 100 MHz clock and the field model on the sensor side
`timescale 1ns/10ps
`default_nettype none
module arc_trip_matrix_test;
  import arc_trip_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       hb_run = 1'b1;
  logic       ce = 1'b1;
  logic [3:0] wanted = 4'hF;
  logic [3:0] light_req = 4'h0;
  logic [3:0] present = 4'hF;
  logic       mode = 1'b0;
  logic       link = 1'b0;
  logic       overlap = 1'b0;
  logic       ocm = 1'b0;
  logic       flag_req = 1'b0;
  logic       reset_req = 1'b0;
  logic       block = 1'b0;
  logic       volt = 1'b1;
  logic [3:0] light;
  logic       flag;
  logic       ext_reset;
  logic       heartbeat;
  logic       z1;
  logic       z2;
  logic       tout;
  logic       relay;
  logic       nc;
  logic       no_c;
  logic [3:0] failed;
  int         errors = 0;
  int         checks = 0;
  always #5 clk = ~clk;
  arc_field_model field (.clk(clk), .hb_run(hb_run), .light_req(light_req),
    .flag_req(flag_req), .reset_req(reset_req), .light(light), .flag(flag),
    .ext_reset(ext_reset), .heartbeat(heartbeat));
  arc_trip_matrix DUT (.CLK_SYS(clk), .RESET(rst), .CE(ce), .LIGHT_SENSOR(light),
    .SENSOR_PRESENT(present), .EXPECTED_SENSORS(wanted), .TRIP_OUT_MODE_SWITCH(mode),
    .TRIP_LINK_SWITCH(link), .ZONE_OVERLAP_SWITCH(overlap), .OVERCURRENT_MODE(ocm),
    .OVERCURRENT_FLAG(flag), .EXT_RESET(ext_reset), .EXT_BLOCK(block),
    .VOLTAGE_OK(volt), .SUP_HEARTBEAT(heartbeat), .ZONE1_TRIP(z1), .ZONE2_TRIP(z2),
    .TRIP_OUT(tout), .SERVICE_FAULT_RELAY(relay), .SF_NC_CLOSED(nc),
    .SF_NO_CLOSED(no_c), .SENSOR_FAILED(failed));
  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // model register, sync, latch and output register is 5 edges, 8 leaves margin
  task automatic lit(input logic [3:0] v);
    light_req <= v;
    cyc(8);
  endtask
  task automatic trips(input string name, input logic [2:0] exp);
    check(name, {1'b0, z1, z2, tout}, {1'b0, exp});
  endtask
  task automatic sf(input string name, input logic [2:0] exp);
    check(name, {1'b0, relay, nc, no_c}, {1'b0, exp});
  endtask
  // light must be gone first, or the latch reloads
  task automatic clr;
    lit(4'h0);
    reset_req <= 1'b1;
    cyc(8);
    reset_req <= 1'b0;
    cyc(8);
  endtask
  task automatic sweep(input string name, input logic [11:0] tab);
    for (int i = 0; i < 4; i++)
    begin
      lit(4'h1 << i);
      trips(name, tab[3*i +: 3]); // per sensor
      lit(4'h0);
      trips("latch", tab[3*i +: 3]); // held after light
      clr();
      trips("clear", 3'b000); // reset clears
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_matrix;
    sweep("zones", 12'b010_010_101_101); // zone map
    mode <= 1'b1;
    sweep("mode", 12'b011_011_100_100); // output from zone 2
    mode <= 1'b0;
    link <= 1'b1;
    sweep("link", 12'hFFF); // linked zones
    link <= 1'b0;
    overlap <= 1'b1;
    sweep("overlap", 12'b010_111_111_101); // middle sensors
    overlap <= 1'b0;
    $display("matrix done");
  endtask
  task automatic t_oc;
    ocm <= 1'b1;
    lit(4'h1);
    trips("no flag", 3'b000); // light alone
    flag_req <= 1'b1;
    cyc(8);
    trips("flag", 3'b101); // light with flag
    flag_req <= 1'b0;
    clr();
    ocm <= 1'b0;
    $display("overcurrent done");
  endtask
  task automatic t_block;
    block <= 1'b1;
    lit(4'h8);
    trips("blocked", 3'b000); // outputs held low
    lit(4'h0);
    block <= 1'b0;
    cyc(8);
    trips("unblocked", 3'b010); // latch kept
    clr();
    $display("block done");
  endtask
  task automatic t_relay;
    sf("healthy", 3'b110); // contacts
    volt <= 1'b0;
    cyc(8);
    sf("no voltage", 3'b001); // power loss
    volt <= 1'b1;
    cyc(8);
    sf("voltage back", 3'b110); // recovery
    $display("relay done");
  endtask
  // enable low must freeze the synchronisers and the latches
  task automatic t_ce;
    ce <= 1'b0;
    lit(4'h1);
    trips("frozen", 3'b000); // no trip while frozen
    ce <= 1'b1;
    cyc(8);
    trips("thawed", 3'b101); // trip after enable
    clr();
    $display("enable done");
  endtask
  // heartbeat loss latches until reset, so restart afterwards
  task automatic t_heartbeat;
    hb_run <= 1'b0;
    cyc(1100);
    sf("heartbeat", 3'b001); // supervision alarm
    hb_run <= 1'b1;
    rst <= 1'b1;
    cyc(8);
    rst <= 1'b0;
    cyc(40);
    sf("restart", 3'b110); // healthy again
    $display("heartbeat done");
  endtask
  task automatic t_failed;
    present <= 4'h7;
    cyc(8);
    sf("count", 3'b001); // wrong sensor count
    check("failed", failed, 4'h8); // sensor marked
    wanted <= 4'h7;
    cyc(8);
    sf("count match", 3'b110); // counts agree again
    lit(4'h8);
    trips("ignored", 3'b000); // failed sensor masked
    clr();
    $display("failed sensor done");
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial
  begin
    cyc(8);
    rst <= 1'b0;
    cyc(40);
    t_matrix();
    t_oc();
    t_block();
    t_ce();
    t_relay();
    t_heartbeat();
    t_failed();
    test_done();
  end
  // whole run needs about 2000 cycles
  initial
  begin
    cyc(20000);
    errors++;
    test_done();
  end
endmodule
`default_nettype wire

// ---- hw/arc_trip_matrix.sv ----
// trip decision matrix of a two-zone arc flash protection unit
// assumes all pin inputs are asynchronous and already level-shifted
`timescale 1ns/10ps
`default_nettype none
// Function
// - sensors 1 and 2 trip zone 1
// - sensors 3 and 4 trip zone 2
// - mode off: combined output follows zone 1
// - mode on: combined output follows zone 2
// - link switch: any sensor trips both zones
// - overlap switch: sensor 2/3 trips both
// - overcurrent mode needs overcurrent flag too
// - reset input clears trip state
// - separate supervision checks logic and voltage
// - failed component's activations are ignored
// - fault relay energized only when voltage good
// - wrong sensor count drops fault relay
// - energized relay: NC closed, NO open
module arc_trip_matrix
  import arc_trip_pkg::*;
(
  input  wire logic                    CLK_SYS,
  input  wire logic                    RESET,
  input  wire logic                    CE,
  input  wire logic [SENSOR_COUNT-1:0] LIGHT_SENSOR,
  input  wire logic [SENSOR_COUNT-1:0] SENSOR_PRESENT,
  input  wire logic [SENSOR_COUNT-1:0] EXPECTED_SENSORS,
  input  wire logic                    TRIP_OUT_MODE_SWITCH,
  input  wire logic                    TRIP_LINK_SWITCH,
  input  wire logic                    ZONE_OVERLAP_SWITCH,
  input  wire logic                    OVERCURRENT_MODE,
  input  wire logic                    OVERCURRENT_FLAG,
  input  wire logic                    EXT_RESET,
  input  wire logic                    EXT_BLOCK,
  input  wire logic                    VOLTAGE_OK,
  input  wire logic                    SUP_HEARTBEAT,
  output var  logic                    ZONE1_TRIP,
  output var  logic                    ZONE2_TRIP,
  output var  logic                    TRIP_OUT,
  output var  logic                    SERVICE_FAULT_RELAY,
  output var  logic                    SF_NC_CLOSED,
  output var  logic                    SF_NO_CLOSED,
  output var  logic [SENSOR_COUNT-1:0] SENSOR_FAILED
);
  import arc_trip_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int unsigned PIN_COUNT = 3 * SENSOR_COUNT + 9;
  logic [PIN_COUNT-1:0] raw_pins;
  logic [PIN_COUNT-1:0] pins;
  assign raw_pins = {LIGHT_SENSOR, SENSOR_PRESENT, EXPECTED_SENSORS,
                     TRIP_OUT_MODE_SWITCH, TRIP_LINK_SWITCH, ZONE_OVERLAP_SWITCH,
                     OVERCURRENT_MODE, OVERCURRENT_FLAG, EXT_RESET, EXT_BLOCK,
                     VOLTAGE_OK, SUP_HEARTBEAT};
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_sync
      pin_sync u_sync
      (
        .clk   (CLK_SYS),
        .rst   (RESET),
        .ce    (CE),
        .pin   (raw_pins[gi]),
        .level (pins[gi])
      );
    end
  endgenerate

  logic [SENSOR_COUNT-1:0] light;
  logic [SENSOR_COUNT-1:0] present;
  logic [SENSOR_COUNT-1:0] expected;
  logic mode_sw;
  logic link_sw;
  logic overlap_sw;
  logic oc_mode;
  logic oc_flag;
  logic ext_reset;
  logic ext_block;
  logic volt_ok;
  logic heartbeat;
  assign {light, present, expected, mode_sw, link_sw, overlap_sw,
          oc_mode, oc_flag, ext_reset, ext_block, volt_ok, heartbeat} = pins;

  // ------------------------------------------------------------
  // supervision
  // ------------------------------------------------------------
  // heartbeat from the separate supervisor must keep toggling
  localparam int unsigned HB_W = $clog2(HEARTBEAT_CYCLES + 1);
  localparam int unsigned ST_W = $clog2(SETTLE_CYCLES + 1);
  logic [HB_W-1:0] hb_count;
  logic            hb_last;
  logic            hb_lost;
  logic [ST_W-1:0] settle_count;
  sup_state_e      sup_state;
  sup_state_e      next_sup_state;
  logic            count_bad;
  logic            sup_ok;

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      hb_last  <= 1'b0;
      hb_count <= '0;
      hb_lost  <= 1'b0;
    end
    else if (CE)
    begin
      hb_last <= heartbeat;
      if (heartbeat != hb_last)
      begin
        hb_count <= '0;
      end
      else if (hb_count == HB_W'(HEARTBEAT_CYCLES))
      begin
        hb_lost <= 1'b1;
      end
      else
      begin
        hb_count <= hb_count + HB_W'(1);
      end
    end
  end

  assign count_bad = ($countones(present) != $countones(expected));

  always_comb
  begin
    next_sup_state = sup_state;
    case (sup_state)
      SUP_START:
      begin
        if (settle_count == ST_W'(SETTLE_CYCLES))
        begin
          next_sup_state = SUP_RUN;
        end
      end
      SUP_RUN:
      begin
        if (hb_lost)
        begin
          next_sup_state = SUP_FAULT;
        end
      end
      SUP_FAULT:
      begin
        next_sup_state = SUP_FAULT;
      end
      default:
      begin
        next_sup_state = SUP_FAULT;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      sup_state    <= SUP_START;
      settle_count <= '0;
    end
    else if (CE)
    begin
      sup_state <= next_sup_state;
      if (sup_state == SUP_START)
      begin
        settle_count <= settle_count + ST_W'(1);
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      SENSOR_FAILED <= '0;
    end
    else if (CE && sup_state == SUP_RUN)
    begin
      SENSOR_FAILED <= SENSOR_FAILED | (expected & ~present);
    end
  end

  assign sup_ok = (sup_state == SUP_RUN) && !count_bad && volt_ok;

  // relay held energized only while healthy
  // sensor count fault drops the relay
  // energized relay closes NC path, opens NO path
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      SERVICE_FAULT_RELAY <= SF_RESET_VALUE;
      SF_NC_CLOSED        <= SF_RESET_VALUE;
      SF_NO_CLOSED        <= ~SF_RESET_VALUE;
    end
    else if (CE)
    begin
      SERVICE_FAULT_RELAY <= sup_ok;
      SF_NC_CLOSED        <= sup_ok;
      SF_NO_CLOSED        <= ~sup_ok;
    end
  end

  // ------------------------------------------------------------
  // trip matrix
  // ------------------------------------------------------------
  logic [SENSOR_COUNT-1:0] active;
  logic zone1_light;
  logic zone2_light;
  logic any_light;
  logic overlap_light;
  logic oc_qualify;
  logic next_zone1_set;
  logic next_zone2_set;
  logic [1:0] trip_latch;

  assign active        = light & ~SENSOR_FAILED;
  assign zone1_light   = active[0] | active[1];
  assign zone2_light   = active[2] | active[3];
  assign any_light     = zone1_light | zone2_light;
  assign overlap_light = active[1] | active[2];
  assign oc_qualify    = !oc_mode || oc_flag;

  // overlap switch on sensors 2 and 3
  always_comb
  begin
    next_zone1_set = zone1_light;
    next_zone2_set = zone2_light;
    if (link_sw)
    begin
      next_zone1_set = any_light;
      next_zone2_set = any_light;
    end
    if (overlap_sw && overlap_light)
    begin
      next_zone1_set = 1'b1;
      next_zone2_set = 1'b1;
    end
    next_zone1_set = next_zone1_set && oc_qualify;
    next_zone2_set = next_zone2_set && oc_qualify;
  end

  // reset input clears, a new activation wins
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      trip_latch <= LATCH_RESET_VALUE;
    end
    else if (CE)
    begin
      if (ext_reset)
      begin
        trip_latch <= {next_zone2_set, next_zone1_set};
      end
      else
      begin
        trip_latch <= trip_latch | {next_zone2_set, next_zone1_set};
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      ZONE1_TRIP <= 1'b0;
      ZONE2_TRIP <= 1'b0;
      TRIP_OUT   <= 1'b0;
    end
    else if (CE)
    begin
      ZONE1_TRIP <= trip_latch[0] && !ext_block;
      ZONE2_TRIP <= trip_latch[1] && !ext_block;
      TRIP_OUT   <= (mode_sw ? trip_latch[1] : trip_latch[0]) && !ext_block;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  zone1_follow_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && $past(CE) |-> ZONE1_TRIP == ($past(trip_latch[0]) && !$past(ext_block)))
    else $error("zone 1 output mismatch");
  zone2_follow_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && $past(CE) |-> ZONE2_TRIP == ($past(trip_latch[1]) && !$past(ext_block)))
    else $error("zone 2 output mismatch");
  mode_off_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && $past(CE) && !$past(mode_sw) |-> TRIP_OUT == ZONE1_TRIP)
    else $error("combined output not zone 1");
  mode_on_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && $past(CE) && $past(mode_sw) |-> TRIP_OUT == ZONE2_TRIP)
    else $error("combined output not zone 2");
  link_both_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && link_sw && any_light && oc_qualify ##1 CE |-> trip_latch == 2'h3)
    else $error("linked zones not both tripped");
  overlap_both_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && overlap_sw && overlap_light && oc_qualify ##1 CE |-> trip_latch == 2'h3)
    else $error("overlap did not trip both");
  oc_gate_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && ext_reset && oc_mode && !oc_flag ##1 CE |-> trip_latch == 2'h0)
    else $error("trip without overcurrent flag");
  latch_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && !ext_reset && trip_latch[0] ##1 CE |-> trip_latch[0])
    else $error("zone latch dropped without reset");
  block_sup_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && ext_block ##1 CE |-> !ZONE1_TRIP && !ZONE2_TRIP && !TRIP_OUT)
    else $error("trip while blocked");
  relay_good_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && !volt_ok ##1 CE |-> !SERVICE_FAULT_RELAY && SF_NO_CLOSED)
    else $error("relay energized without voltage");
  relay_count_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && count_bad ##1 CE |-> !SERVICE_FAULT_RELAY)
    else $error("relay energized with bad sensor count");
  relay_path_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    SF_NC_CLOSED == SERVICE_FAULT_RELAY && SF_NO_CLOSED != SERVICE_FAULT_RELAY)
    else $error("relay contact paths inconsistent");
  failed_mask_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (active & SENSOR_FAILED) == '0)
    else $error("failed sensor still active");
  heartbeat_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CE && hb_lost && sup_state == SUP_RUN ##1 CE |-> sup_state == SUP_FAULT)
    else $error("lost heartbeat not flagged");
endmodule
`default_nettype wire

// ---- hw/arc_trip_pkg.sv ----
// constants for the two-zone arc trip decision logic
// assumes one 100 MHz system clock and synchronous reset
package arc_trip_pkg;
  localparam int unsigned SENSOR_COUNT = 4;
  localparam int unsigned SYNC_STAGES  = 2;
  // sensor supervision states
  typedef enum logic [2:0]
  {
    SUP_START = 3'b001,
    SUP_RUN   = 3'b010,
    SUP_FAULT = 3'b100
  } sup_state_e;
  localparam logic [1:0] LATCH_RESET_VALUE = 2'h0;
  localparam logic       SF_RESET_VALUE    = 1'b0;
  // supervision heartbeat must toggle within this time
  localparam int unsigned HEARTBEAT_TIMEOUT_US = 10;
  localparam int unsigned CLK_MHZ              = 100;
  localparam int unsigned HEARTBEAT_CYCLES     = HEARTBEAT_TIMEOUT_US * CLK_MHZ;
  // startup settling time before supervision may alarm
  localparam int unsigned SETTLE_CYCLES        = 16;
endpackage

// ---- hw/pin_sync.sv ----
// two-stage synchroniser for one asynchronous pin
// assumes the pin may change at any time relative to clk
`timescale 1ns/10ps
`default_nettype none
module pin_sync
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic pin,
  output var  logic level
);
  logic stage1;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      level  <= 1'b0;
    end
    else if (ce)
    begin
      stage1 <= pin;
      level  <= stage1;
    end
  end
endmodule
`default_nettype wire
